// [test/psram_ctrl_model.sv]
// Behavioural memory controller that drives the static memory port and checks what it returns.
`timescale 1ns/1ns
module psram_ctrl_model (
   input wire logic ref_clk,
   output logic [psram_pkg::ADDR_W-1:0] address_in,
   output logic advance_or_load,
   output logic read_not_write,
   output logic clock_enable_n,
   output logic chip_select_first_n,
   output logic chip_select_second,
   output logic chip_select_third_n,
   output logic [psram_pkg::LANES-1:0] byte_write_strobe_n,
   output logic output_enable_n,
   output logic burst_order_select,
   output logic sleep_request,
   output logic [psram_pkg::DATA_W-1:0] data_io_i,
   output logic [psram_pkg::LANES-1:0] parity_io_i,
   input wire logic [psram_pkg::DATA_W-1:0] data_io_o,
   input wire logic [psram_pkg::LANES-1:0] parity_io_o,
   input wire logic data_io_oe,
   input wire logic parity_io_oe
);
   logic [35:0] shadow [logic [17:0]];
   int cs_bad = 0;
   bit mute = 1'b0;
   int p1_k = 0;
   int p2_k = 0;
   int b_k = 0;
   logic [17:0] p1_a, p2_a, b_a;
   logic [35:0] p1_w, p2_w, p1_e, p2_e;
   logic [3:0] p1_s, p2_s;
   logic [1:0] cnt;

   initial begin
      {address_in, advance_or_load, read_not_write, clock_enable_n, chip_select_second} = '0;
      {chip_select_first_n, chip_select_third_n, byte_write_strobe_n} = '1;
      {output_enable_n, burst_order_select, sleep_request, data_io_i, parity_io_i} = '0;
   end

   // One bus cycle: k is 0 deselect, 1 load read, 2 load write, 3 advance; called just after a rising edge.
   task automatic step(input int k, input logic [17:0] a, input logic [35:0] w, input logic [3:0] s,
                       input logic ce_n);
      int nk;
      logic [17:0] na;
      logic [35:0] got;
      nk = 0;
      na = a;
      // The array is read one active edge after the command, before the write of that same edge lands.
      if (p1_k == 1) p1_e = shadow[p1_a];
      if (p2_k == 2) begin
         for (int g = 0; g < 4; g++) {parity_io_i[g], data_io_i[8*g+:8]} = p2_w[9*g+:9];
         for (int g = 0; g < 4; g++) if (!ce_n && !p2_s[g]) shadow[p2_a][9*g+:9] = p2_w[9*g+:9];
      end else begin
         // A released bus must not hold its last value, or a stale sample would pass.
         data_io_i = ~data_io_i;
         parity_io_i = ~parity_io_i;
      end
      clock_enable_n = ce_n;
      advance_or_load = (k == 3);
      read_not_write = (k == 1);
      byte_write_strobe_n = s;
      chip_select_first_n = (k == 0) || (cs_bad == 1);
      chip_select_second = (k != 0) && (cs_bad != 2);
      chip_select_third_n = (k == 0) || (cs_bad == 3);
      address_in = (k == 3) ? ~address_in : a;
      if (!ce_n && !mute && cs_bad == 0) begin
         if (k == 0) b_k = 0;
         if (k == 1 || k == 2) begin
            nk = k;
            b_a = a;
            b_k = k;
            cnt = 2'h1;
         end
         if (k == 3) begin
            na = {b_a[17:2], burst_order_select ? b_a[1:0] ^ cnt : b_a[1:0] + cnt};
            nk = b_k;
            cnt = cnt + 2'h1;
         end
      end
      @(posedge ref_clk);
      #1;
      if (!ce_n) begin
         if (p2_k == 1) begin
            for (int g = 0; g < 4; g++) got[9*g+:9] = {parity_io_o[g], data_io_o[8*g+:8]};
            tb_top.chk_word(got, p2_e, "read data");
            tb_top.chk_bit(data_io_oe, !output_enable_n, "data pin enable");
            tb_top.chk_bit(parity_io_oe, !output_enable_n, "parity pin enable");
         end
         {p2_k, p2_a, p2_w, p2_s, p2_e} = {p1_k, p1_a, p1_w, p1_s, p1_e};
         {p1_k, p1_a, p1_w, p1_s} = {nk, na, w, s};
      end
   endtask
endmodule

// [test/tb_top.sv]
// Self-checking bench for the pipelined static memory port.
`timescale 1ns/1ns
module tb_top;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [17:0] address_in;
   logic advance_or_load, read_not_write, clock_enable_n, chip_select_first_n, chip_select_second;
   logic chip_select_third_n, output_enable_n, burst_order_select, sleep_request, sleeping;
   logic data_io_oe, parity_io_oe;
   logic [3:0] byte_write_strobe_n, parity_io_i, parity_io_o;
   logic [31:0] data_io_i, data_io_o;
   int miscompares = 0;
   int checks = 0;

   always #5 ref_clk = ~ref_clk;

   psram_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .address_in(address_in), .advance_or_load(advance_or_load),
      .read_not_write(read_not_write), .clock_enable_n(clock_enable_n), .chip_select_first_n(chip_select_first_n),
      .chip_select_second(chip_select_second), .chip_select_third_n(chip_select_third_n),
      .byte_write_strobe_n(byte_write_strobe_n), .output_enable_n(output_enable_n),
      .burst_order_select(burst_order_select), .sleep_request(sleep_request), .data_io_i(data_io_i),
      .data_io_o(data_io_o), .data_io_oe(data_io_oe), .parity_io_i(parity_io_i), .parity_io_o(parity_io_o),
      .parity_io_oe(parity_io_oe), .sleeping(sleeping));

   psram_ctrl_model ctrl_u (.ref_clk(ref_clk), .address_in(address_in), .advance_or_load(advance_or_load),
      .read_not_write(read_not_write), .clock_enable_n(clock_enable_n), .chip_select_first_n(chip_select_first_n),
      .chip_select_second(chip_select_second), .chip_select_third_n(chip_select_third_n),
      .byte_write_strobe_n(byte_write_strobe_n), .output_enable_n(output_enable_n),
      .burst_order_select(burst_order_select), .sleep_request(sleep_request), .data_io_i(data_io_i),
      .parity_io_i(parity_io_i), .data_io_o(data_io_o), .parity_io_o(parity_io_o), .data_io_oe(data_io_oe),
      .parity_io_oe(parity_io_oe));

   task automatic chk_word(input logic [35:0] got, input logic [35:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string what);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   function automatic logic [35:0] dv(input logic [17:0] a, input logic [35:0] k);
      return {a, ~a} ^ k;
   endfunction

   task automatic idle(input int n);
      repeat (n) ctrl_u.step(0, 18'h00000, 36'h0, 4'hF, 1'b0);
   endtask

   task automatic t_rw;
      for (logic [17:0] a = 18'h00010; a < 18'h00014; a++) ctrl_u.step(2, a, dv(a, 36'h0), 4'h0, 1'b0);
      for (logic [17:0] a = 18'h00010; a < 18'h00014; a++) begin
         ctrl_u.step(1, a, 36'h0, 4'hF, 1'b0);
         ctrl_u.step(2, a + 18'h10, dv(a, 36'hF0F0F0F0F), 4'h0, 1'b0);
      end
      ctrl_u.step(2, 18'h00011, 36'hFFFFFFFFF, 4'hA, 1'b0);
      for (logic [17:0] a = 18'h00020; a < 18'h00024; a++) ctrl_u.step(1, a, 36'h0, 4'hF, 1'b0);
      ctrl_u.step(1, 18'h00011, 36'h0, 4'hF, 1'b0);
      idle(2);
      $display("test write_read done");
   endtask

   task automatic t_burst;
      for (logic [17:0] a = 18'h00100; a < 18'h00104; a++) ctrl_u.step(2, a, dv(a, 36'h0), 4'h0, 1'b0);
      for (int o = 0; o < 2; o++) begin
         for (logic [17:0] s = 18'h00100; s < 18'h00104; s++) begin
            // The order select only moves while the bus is idle, so no burst sees it change.
            ctrl_u.burst_order_select = o[0];
            idle(4);
            ctrl_u.step(1, s, 36'h0, 4'hF, 1'b0);
            repeat (5) ctrl_u.step(3, 18'h00000, 36'h0, 4'hF, 1'b0);
         end
      end
      ctrl_u.step(2, 18'h00200, dv(18'h00200, 36'h0), 4'h0, 1'b0);
      for (logic [17:0] a = 18'h00201; a < 18'h00204; a++) ctrl_u.step(3, a, dv(a, 36'h0), 4'h0, 1'b0);
      idle(2);
      for (logic [17:0] a = 18'h00200; a < 18'h00204; a++) ctrl_u.step(1, a, 36'h0, 4'hF, 1'b0);
      idle(2);
      $display("test burst done");
   endtask

   task automatic t_sel;
      for (int i = 1; i < 4; i++) begin
         ctrl_u.cs_bad = i;
         ctrl_u.mute = 1'b1;
         ctrl_u.step(2, 18'h00100, 36'h0, 4'h0, 1'b0);
         ctrl_u.cs_bad = 0;
         ctrl_u.mute = 1'b0;
         idle(2);
      end
      ctrl_u.step(1, 18'h00100, 36'h0, 4'hF, 1'b0);
      idle(2);
      $display("test selects done");
   endtask

   task automatic t_susp;
      ctrl_u.step(1, 18'h00100, 36'h0, 4'hF, 1'b0);
      ctrl_u.step(2, 18'h00300, dv(18'h00300, 36'h123456789), 4'h0, 1'b0);
      repeat (3) ctrl_u.step(2, 18'h00101, 36'h0, 4'h0, 1'b1);
      idle(3);
      ctrl_u.step(1, 18'h00300, 36'h0, 4'hF, 1'b0);
      ctrl_u.step(1, 18'h00101, 36'h0, 4'hF, 1'b0);
      idle(2);
      $display("test suspend done");
   endtask

   task automatic t_oe;
      ctrl_u.output_enable_n = 1'b1;
      ctrl_u.step(1, 18'h00102, 36'h0, 4'hF, 1'b0);
      idle(3);
      ctrl_u.output_enable_n = 1'b0;
      ctrl_u.step(1, 18'h00103, 36'h0, 4'hF, 1'b0);
      idle(2);
      #2 ctrl_u.output_enable_n = 1'b1;
      #1 chk_bit(data_io_oe, 1'b0, "pin enable off mid cycle");
      ctrl_u.output_enable_n = 1'b0;
      #1 chk_bit(data_io_oe, 1'b1, "pin enable on mid cycle");
      @(posedge ref_clk);
      #1;
      idle(1);
      $display("test output enable done");
   endtask

   task automatic t_sleep;
      int n;
      ctrl_u.step(0, 18'h00000, 36'h0, 4'hF, 1'b1);
      ctrl_u.sleep_request = 1'b1;
      n = 0;
      while (sleeping !== 1'b1 && n < 20) begin
         ctrl_u.step(0, 18'h00000, 36'h0, 4'hF, 1'b1);
         n++;
      end
      chk_bit(n >= 3 && n <= 7, 1'b1, "sleep entry delay");
      ctrl_u.mute = 1'b1;
      ctrl_u.step(2, 18'h00100, 36'h0, 4'h0, 1'b0);
      ctrl_u.mute = 1'b0;
      ctrl_u.sleep_request = 1'b0;
      n = 0;
      while (sleeping !== 1'b0 && n < 20) begin
         idle(1);
         n++;
      end
      chk_bit(n >= 2 && n <= 6, 1'b1, "sleep exit delay");
      idle(4);
      ctrl_u.step(1, 18'h00100, 36'h0, 4'hF, 1'b0);
      idle(2);
      $display("test sleep done");
   endtask

   task automatic conclude;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      idle(4);
      t_rw();
      t_burst();
      t_sel();
      t_susp();
      t_oe();
      t_sleep();
      conclude();
   end

   initial begin
      #50000;
      miscompares++;
      $display("mismatch at %0t: watchdog expired", $time);
      conclude();
   end
endmodule

// [verilog/psram_fifo.sv]
// Small flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module psram_fifo #(
   parameter int WIDTH = 22,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   psram_fifo_if.store port
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [AW:0] wp_q;
   logic [AW:0] wp_d;
   logic [AW:0] rp_q;
   logic [AW:0] rp_d;
   logic full;
   logic empty;
   logic push;
   logic pop;

   // An extra pointer bit tells a full queue from an empty one without a counter.
   assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
   assign empty = (wp_q == rp_q);
   assign push = port.in_valid && !full;
   assign pop = port.out_ready && !empty;
   assign port.in_ready = !full;
   assign port.out_valid = !empty;
   assign port.out_data = mem_q[rp_q[AW-1:0]];

   always_comb begin
      wp_d = push ? wp_q + 1'b1 : wp_q;
      rp_d = pop ? rp_q + 1'b1 : rp_q;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
      end
   end

   for (genvar g = 0; g < DEPTH; g++) begin : g_entry
      always_comb begin
         mem_d[g] = (push && (wp_q[AW-1:0] == AW'(g))) ? port.in_data : mem_q[g];
      end
      always_ff @(posedge clk) begin
         mem_q[g] <= mem_d[g];
      end
   end
endmodule

// [verilog/psram_fifo_if.sv]
// Valid/ready carrier between the write request queue and its user.
`timescale 1ns/1ns
interface psram_fifo_if #(parameter int W = 22);
   logic in_valid;
   logic in_ready;
   logic [W-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [W-1:0] out_data;
   modport store (input in_valid, input in_data, input out_ready, output in_ready, output out_valid, output out_data);
   modport user (output in_valid, output in_data, output out_ready, input in_ready, input out_valid, input out_data);
endinterface

// [verilog/psram_pkg.sv]
// Shared constants and types for the pipelined no-turnaround static memory port.
package psram_pkg;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 32;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int WORD_W = 36;
   localparam int DEPTH = 262144;
   localparam int FIFO_DEPTH = 8;
   localparam int BURST_W = 2;
   localparam logic [1:0] SLEEP_ENTER_CYC = 2'h2;
   localparam logic [1:0] SLEEP_WAKE_CYC = 2'h2;
   localparam logic [1:0] PWR_CNT_RST = 2'h0;
   localparam logic [BURST_W-1:0] BURST_CNT_RST = 2'h0;
   localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
   localparam logic [WORD_W-1:0] WORD_RST = 36'h000000000;

   typedef enum logic [3:0] {
      PWR_AWAKE = 4'h1,
      PWR_ENTER = 4'h2,
      PWR_ASLEEP = 4'h4,
      PWR_WAKE = 4'h8
   } psram_pwr_e;

   typedef enum logic [2:0] {
      OP_IDLE = 3'h1,
      OP_READ = 3'h2,
      OP_WRITE = 3'h4
   } psram_op_e;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [LANES-1:0] strobe_n;
   } psram_wreq_s;

   localparam int WREQ_W = $bits(psram_wreq_s);
endpackage

// [verilog/psram_top.sv]
// Pipelined static memory port with late write and no bus turnaround cycles.
`timescale 1ns/1ns
// How it works
// - Address, data and controls except three async pins are sampled on ref_clk rising edges.
// - Sleep request is asynchronous and is not gated by clock enable or selects.
// - Output enable drives the data pin enables combinationally at any time.
// - Writes start on a clock edge and the array write is generated inside.
// - Read data is latched in an output register, then driven one edge later.
// - Reads and writes mix on consecutive cycles with no idle turnaround.
// - Read/write select high means read, low means write.
// - Inactive clock enable suspends operation for as long as it stays inactive.
// - A cycle starts only when all three chip selects are active.
// - The two low address bits loaded at burst start are combined with a burst counter that starts at 1.
// - Two burst orders exist, linear and interleaved, picked by burst order select.
// - With clock enable high, synchronous inputs are ignored and registers hold, except the sleep sequencer and input synchronisers.
// - Burst order select low gives linear order, high gives interleaved order.
// - Sleep is entered 5 cycles after request rises, wake takes 2 cycles in the wake state.
module psram_top (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [psram_pkg::ADDR_W-1:0] address_in,
   input wire logic advance_or_load,
   input wire logic read_not_write,
   input wire logic clock_enable_n,
   input wire logic chip_select_first_n,
   input wire logic chip_select_second,
   input wire logic chip_select_third_n,
   input wire logic [psram_pkg::LANES-1:0] byte_write_strobe_n,
   input wire logic output_enable_n,
   input wire logic burst_order_select,
   input wire logic sleep_request,
   input wire logic [psram_pkg::DATA_W-1:0] data_io_i,
   output logic [psram_pkg::DATA_W-1:0] data_io_o,
   output logic data_io_oe,
   input wire logic [psram_pkg::LANES-1:0] parity_io_i,
   output logic [psram_pkg::LANES-1:0] parity_io_o,
   output logic parity_io_oe,
   output logic sleeping
);
   logic rst_meta_q;
   logic rst_q_n;
   logic sleep_meta_q;
   logic sleep_s_q;
   logic order_meta_q;
   logic order_s_q;
   psram_pkg::psram_pwr_e pwr_q;
   psram_pkg::psram_pwr_e pwr_d;
   logic [1:0] pwr_cnt_q;
   logic [1:0] pwr_cnt_d;
   psram_pkg::psram_op_e op_q;
   psram_pkg::psram_op_e op_d;
   logic [psram_pkg::ADDR_W-1:0] base_q;
   logic [psram_pkg::ADDR_W-1:0] base_d;
   logic [psram_pkg::BURST_W-1:0] cnt_q;
   logic [psram_pkg::BURST_W-1:0] cnt_d;
   logic [psram_pkg::LANES-1:0] strobe_q;
   logic [psram_pkg::LANES-1:0] strobe_d;
   logic rd1_q;
   logic rd1_d;
   logic rd2_q;
   logic rd2_d;
   logic drive_q;
   logic drive_d;
   logic w1_q;
   logic w1_d;
   logic w2_q;
   logic w2_d;
   logic [psram_pkg::ADDR_W-1:0] rd_addr_q;
   logic [psram_pkg::ADDR_W-1:0] rd_addr_d;
   logic [psram_pkg::WORD_W-1:0] rdata_q;
   logic [psram_pkg::WORD_W-1:0] rdata_d;
   logic [psram_pkg::WORD_W-1:0] dout_q;
   logic [psram_pkg::WORD_W-1:0] dout_d;
   logic [psram_pkg::WORD_W-1:0] mem_q [psram_pkg::DEPTH];
   logic [psram_pkg::WORD_W-1:0] wword;
   logic [psram_pkg::WORD_W-1:0] wold;
   logic act;
   logic sel;
   logic load;
   logic cont;
   logic issue_rd;
   logic issue_wr;
   logic wr_commit;
   logic [psram_pkg::BURST_W-1:0] burst_lsb;
   logic [psram_pkg::ADDR_W-1:0] burst_addr;
   psram_pkg::psram_wreq_s wreq_in;
   psram_pkg::psram_wreq_s wreq_out;

   psram_fifo_if #(.W(psram_pkg::WREQ_W)) wq_if ();

   psram_fifo #(.WIDTH(psram_pkg::WREQ_W), .DEPTH(psram_pkg::FIFO_DEPTH)) u_wq (
      .clk(ref_clk),
      .rst_n(rst_q_n),
      .port(wq_if.store)
   );

   // Release of reset is synchronised; assertion stays asynchronous.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_q_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_q_n <= rst_meta_q;
      end
   end

   // Sleep request and burst order select pass two flip-flops before any logic reads them.
   always_ff @(posedge ref_clk or negedge rst_q_n) begin
      if (!rst_q_n) begin
         sleep_meta_q <= 1'b0;
         sleep_s_q <= 1'b0;
         order_meta_q <= 1'b0;
         order_s_q <= 1'b0;
      end else begin
         sleep_meta_q <= sleep_request;
         sleep_s_q <= sleep_meta_q;
         order_meta_q <= burst_order_select;
         order_s_q <= order_meta_q;
      end
   end

   // Sleep sequencing ignores clock enable and selects entirely.
   always_comb begin
      pwr_d = pwr_q;
      pwr_cnt_d = pwr_cnt_q;
      unique case (pwr_q)
         psram_pkg::PWR_AWAKE: begin
            if (sleep_s_q) begin
               pwr_d = psram_pkg::PWR_ENTER;
               pwr_cnt_d = psram_pkg::PWR_CNT_RST;
            end
         end
         psram_pkg::PWR_ENTER: begin
            pwr_cnt_d = pwr_cnt_q + 2'h1;
            if (pwr_cnt_q == psram_pkg::SLEEP_ENTER_CYC - 2'h1) begin
               pwr_d = psram_pkg::PWR_ASLEEP;
            end
         end
         psram_pkg::PWR_ASLEEP: begin
            if (!sleep_s_q) begin
               pwr_d = psram_pkg::PWR_WAKE;
               pwr_cnt_d = psram_pkg::PWR_CNT_RST;
            end
         end
         psram_pkg::PWR_WAKE: begin
            pwr_cnt_d = pwr_cnt_q + 2'h1;
            if (pwr_cnt_q == psram_pkg::SLEEP_WAKE_CYC - 2'h1) begin
               pwr_d = psram_pkg::PWR_AWAKE;
            end
         end
         default: begin
            pwr_d = psram_pkg::PWR_AWAKE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_q_n) begin
      if (!rst_q_n) begin
         pwr_q <= psram_pkg::PWR_AWAKE;
         pwr_cnt_q <= psram_pkg::PWR_CNT_RST;
         sleeping <= 1'b0;
      end else begin
         pwr_q <= pwr_d;
         pwr_cnt_q <= pwr_cnt_d;
         sleeping <= (pwr_d == psram_pkg::PWR_ASLEEP);
      end
   end

   // Only active clocks advance anything but the sleep sequencer and synchronisers; a stalled queue also refuses new commands.
   assign act = !clock_enable_n && ((pwr_q == psram_pkg::PWR_AWAKE) || (pwr_q == psram_pkg::PWR_ENTER));
   assign sel = !chip_select_first_n && chip_select_second && !chip_select_third_n;
   assign load = act && !advance_or_load && sel && wq_if.in_ready;
   assign cont = act && advance_or_load && (op_q != psram_pkg::OP_IDLE) && wq_if.in_ready;
   assign burst_lsb = order_s_q ? (base_q[1:0] ^ cnt_q) : (base_q[1:0] + cnt_q);
   assign burst_addr = load ? address_in : {base_q[psram_pkg::ADDR_W-1:2], burst_lsb};
   assign issue_rd = (load && read_not_write) || (cont && (op_q == psram_pkg::OP_READ));
   assign issue_wr = (load && !read_not_write) || (cont && (op_q == psram_pkg::OP_WRITE));
   assign wreq_in.addr = burst_addr;
   assign wreq_in.strobe_n = load ? byte_write_strobe_n : strobe_q;
   assign wq_if.in_valid = issue_wr;
   assign wq_if.in_data = wreq_in;
   assign wreq_out = wq_if.out_data;
   assign wr_commit = act && w2_q && wq_if.out_valid;
   assign wq_if.out_ready = wr_commit;

   // Burst control: a load stores the address as base and sets the counter to 1.
   always_comb begin
      op_d = op_q;
      base_d = base_q;
      cnt_d = cnt_q;
      strobe_d = strobe_q;
      if (load) begin
         op_d = read_not_write ? psram_pkg::OP_READ : psram_pkg::OP_WRITE;
         base_d = address_in;
         cnt_d = 2'h1;
         strobe_d = byte_write_strobe_n;
      end else if (act && !advance_or_load) begin
         op_d = psram_pkg::OP_IDLE;
      end else if (cont) begin
         cnt_d = cnt_q + 2'h1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_q_n) begin
      if (!rst_q_n) begin
         op_q <= psram_pkg::OP_IDLE;
         base_q <= psram_pkg::ADDR_RST;
         cnt_q <= psram_pkg::BURST_CNT_RST;
         strobe_q <= '1;
      end else begin
         op_q <= op_d;
         base_q <= base_d;
         cnt_q <= cnt_d;
         strobe_q <= strobe_d;
      end
   end

   // Read and write pipelines share one stage clock, so opposite cycles never collide.
   always_comb begin
      rd1_d = rd1_q;
      rd2_d = rd2_q;
      drive_d = drive_q;
      w1_d = w1_q;
      w2_d = w2_q;
      rd_addr_d = rd_addr_q;
      rdata_d = rdata_q;
      dout_d = dout_q;
      if (act) begin
         rd1_d = issue_rd;
         rd_addr_d = issue_rd ? burst_addr : rd_addr_q;
         rd2_d = rd1_q;
         rdata_d = rd1_q ? mem_q[rd_addr_q] : rdata_q;
         drive_d = rd2_q;
         dout_d = rd2_q ? rdata_q : dout_q;
         w1_d = issue_wr;
         w2_d = w1_q;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_q_n) begin
      if (!rst_q_n) begin
         rd1_q <= 1'b0;
         rd2_q <= 1'b0;
         drive_q <= 1'b0;
         w1_q <= 1'b0;
         w2_q <= 1'b0;
         rd_addr_q <= psram_pkg::ADDR_RST;
         rdata_q <= psram_pkg::WORD_RST;
         dout_q <= psram_pkg::WORD_RST;
      end else begin
         rd1_q <= rd1_d;
         rd2_q <= rd2_d;
         drive_q <= drive_d;
         w1_q <= w1_d;
         w2_q <= w2_d;
         rd_addr_q <= rd_addr_d;
         rdata_q <= rdata_d;
         dout_q <= dout_d;
      end
   end

   // Lane merge keeps unstrobed bytes; each lane is a byte plus its parity bit.
   assign wold = mem_q[wreq_out.addr];
   for (genvar g = 0; g < psram_pkg::LANES; g++) begin : g_lane
      assign wword[g*psram_pkg::LANE_W +: psram_pkg::LANE_W] = wreq_out.strobe_n[g] ?
         wold[g*psram_pkg::LANE_W +: psram_pkg::LANE_W] : {parity_io_i[g], data_io_i[g*8 +: 8]};
      assign data_io_o[g*8 +: 8] = dout_q[g*psram_pkg::LANE_W +: 8];
      assign parity_io_o[g] = dout_q[g*psram_pkg::LANE_W + 8];
   end

   // The array is far too large for a next-value copy, so it is written in place.
   always_ff @(posedge ref_clk) begin
      if (wr_commit) begin
         mem_q[wreq_out.addr] <= wword;
      end
   end

   // The pin enable must follow output enable with no clock, so it is not registered.
   assign data_io_oe = drive_q && !output_enable_n;
   assign parity_io_oe = drive_q && !output_enable_n;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_q_n);

   read_pipe_a: assert property (issue_rd ##1 act ##1 act |=> drive_q) else $error("Read data not driven on second edge.");
   oe_async_a: assert property (output_enable_n |-> !data_io_oe && !parity_io_oe) else $error("Pins driven while disabled.");
   suspend_hold_a: assert property (clock_enable_n |=> $stable(cnt_q) && $stable(op_q) && $stable(drive_q) && $stable(w2_q))
      else $error("State moved during suspend.");
   write_late_a: assert property (issue_wr ##1 act ##1 act |-> wr_commit) else $error("Write data not taken two cycles late.");
   burst_wrap_a: assert property (cont [*4] |-> cnt_q == $past(cnt_q, 3) + 2'h3) else $error("Burst counter did not wrap.");
   burst_order_a: assert property (cont && order_s_q |-> burst_addr == {base_q[17:2], base_q[1:0] ^ cnt_q})
      else $error("Interleaved burst address wrong.");
   select_gate_a: assert property (act && !advance_or_load && !sel |=> op_q == psram_pkg::OP_IDLE && !w1_q && !rd1_q)
      else $error("Cycle started without all selects.");
   sleep_enter_a: assert property (pwr_q == psram_pkg::PWR_AWAKE && sleep_s_q |=>
      pwr_q == psram_pkg::PWR_ENTER ##1 pwr_q == psram_pkg::PWR_ENTER ##1 pwr_q == psram_pkg::PWR_ASLEEP)
      else $error("Sleep entry timing wrong.");
   sleep_wake_a: assert property (pwr_q == psram_pkg::PWR_ASLEEP && !sleep_s_q |=>
      pwr_q == psram_pkg::PWR_WAKE ##1 pwr_q == psram_pkg::PWR_WAKE ##1 pwr_q == psram_pkg::PWR_AWAKE)
      else $error("Wake-up timing wrong.");
   asleep_quiet_a: assert property (pwr_q == psram_pkg::PWR_ASLEEP |-> !issue_rd && !issue_wr)
      else $error("Cycle started while asleep.");

   rd_wr_cover_c: cover property (issue_rd ##1 issue_wr ##1 issue_rd);
   burst_four_c: cover property (load ##1 cont ##1 cont ##1 cont);
   suspend_c: cover property (issue_wr ##1 clock_enable_n [*3] ##1 act ##1 wr_commit);
   sleep_c: cover property (pwr_q == psram_pkg::PWR_ASLEEP ##1 pwr_q == psram_pkg::PWR_WAKE);
endmodule
